// ==== src/adcc_pkg.sv ====
// constants, register map and field layout of the converter control block
// assumes a 32-bit ahb-lite register bus and one 25 MHz system clock
package adcc_pkg;
   // =========================================================
   // register indices; byte address is four times the index
   localparam logic [8:0] IDX_AE_LOW = 9'h04A;
   localparam logic [8:0] IDX_AE_HIGH = 9'h04B;
   localparam logic [8:0] IDX_CTL_MAIN = 9'h1B0;
   localparam logic [8:0] IDX_CTL_SETUP = 9'h1B2;
   localparam logic [8:0] IDX_RESULT = 9'h1B4;
   // =========================================================
   // reset values
   localparam logic [15:0] RST_CTL_MAIN = 16'h0000;
   localparam logic [15:0] RST_CTL_SETUP = 16'h0000;
   localparam logic [7:0] RST_AE = 8'h00;
   // =========================================================
   // main control word fields
   localparam int B_REF_BURST = 8;
   localparam int B_MSC = 7;
   localparam int B_REF_LEVEL = 6;
   localparam int B_REF_ON = 5;
   localparam int B_CONV_ON = 4;
   localparam int B_DONE_IE = 3;
   localparam int B_DONE_FLAG = 2;
   localparam int B_ENC = 1;
   localparam int B_SW_START = 0;
   localparam int MAIN_LOCK_LSB = 4;
   // =========================================================
   // setup word fields
   localparam int F_CHAN_MSB = 15;
   localparam int F_CHAN_LSB = 12;
   localparam int F_TRIG_MSB = 11;
   localparam int F_TRIG_LSB = 10;
   localparam int B_FORMAT = 9;
   localparam int B_INVERT = 8;
   localparam int F_DIV_MSB = 7;
   localparam int F_DIV_LSB = 5;
   localparam int F_SRC_MSB = 4;
   localparam int F_SRC_LSB = 3;
   localparam int F_SEQ_MSB = 2;
   localparam int F_SEQ_LSB = 1;
   localparam int B_BUSY = 0;
   localparam logic [3:0] HIGH_MASK_USED = 4'hF;
   // =========================================================
   // modes and codes
   typedef enum logic [1:0] {
      ADCC_SEQ_SINGLE = 2'b00,
      ADCC_SEQ_SEQUENCE = 2'b01,
      ADCC_SEQ_REPEAT_SINGLE = 2'b10,
      ADCC_SEQ_REPEAT_SEQUENCE = 2'b11
   } adcc_seq_t;
   localparam logic [1:0] TRIG_SW = 2'b00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HRESP_OKAY = 2'b00;
   localparam logic [3:0] CHAN_LAST = 4'h0;
   // =========================================================
   // timing: converter clocks per sample and conversion
   localparam int CONV_TICKS = 16;
endpackage : adcc_pkg

// ==== src/adcc_core_if.sv ====
// handshake between the sequencer and the converter timing core
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface adcc_core_if;
   logic start;
   logic [1:0] src_sel;
   logic [2:0] div;
   logic done;
   logic active;
   modport seq (output start, output src_sel, output div, input done, input active);
   modport core (input start, input src_sel, input div, output done, output active);
endinterface : adcc_core_if

// ==== src/adcc_conv_core.sv ====
// converter clock selection, division and conversion timing
// assumes clock sources arrive as one-cycle enable pulses on the system clock
`timescale 1ns/1ps
module adcc_conv_core
   import adcc_pkg::*;
#(
   parameter int TICKS = CONV_TICKS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_src_en,
   adcc_core_if.core bus
);
   logic [2:0] div_cnt_reg;
   logic [5:0] tick_cnt_reg;
   logic src_pulse;
   logic tick;

   // =========================================================
   // source select and divider
   assign src_pulse = i_src_en[bus.src_sel];
   assign tick = src_pulse && (div_cnt_reg == bus.div);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt_reg <= 3'h0;
      end else if (bus.start) begin
         div_cnt_reg <= 3'h0;
      end else if (tick) begin
         div_cnt_reg <= 3'h0;
      end else if (src_pulse) begin
         div_cnt_reg <= div_cnt_reg + 3'h1;
      end
   end

   // =========================================================
   // conversion timer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt_reg <= 6'h00;
         bus.active <= 1'b0;
         bus.done <= 1'b0;
      end else begin
         bus.done <= 1'b0;
         if (bus.start) begin
            tick_cnt_reg <= 6'h00;
            bus.active <= 1'b1;
         end else if (bus.active && tick) begin
            if (tick_cnt_reg == 6'(TICKS - 1)) begin
               bus.active <= 1'b0;
               bus.done <= 1'b1;
            end else begin
               tick_cnt_reg <= tick_cnt_reg + 6'h01;
            end
         end
      end
   end
endmodule : adcc_conv_core

// ==== src/adcc_top.sv ====
// converter control and status registers with conversion sequencer
// assumes an ahb-lite master, analog result on i_conv_data at done,
// and clock sources given as enable pulses on i_clk
`timescale 1ns/1ps
module adcc_top
   import adcc_pkg::*;
#(
   parameter int TICKS = CONV_TICKS
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic [1:0] o_hresp,
   input wire logic [2:0] i_timer_out,
   input wire logic [3:0] i_clk_src_en,
   input wire logic [9:0] i_conv_data,
   input wire logic i_global_irq_enable,
   input wire logic i_irq_ack,
   input wire logic i_block_xfer_on,
   input wire logic i_block_done,
   output logic o_irq,
   output logic o_ref_gen_on,
   output logic o_ref_level_sel,
   output logic o_ref_buffer_on,
   output logic o_converter_on,
   output logic o_sampling,
   output logic [3:0] o_channel,
   output logic [15:0] o_analog_enable
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01,
      ST_WAIT_TRIG = 2'b10
   } adcc_state_t;

   adcc_core_if cif ();
   adcc_state_t state_reg;
   logic [15:0] ctl_main_reg;
   logic [15:0] ctl_setup_reg;
   logic [7:0] ae_low_reg;
   logic [7:0] ae_high_reg;
   logic [9:0] result_reg;
   logic [3:0] chan_reg;
   logic wr_pend_reg;
   logic [8:0] wr_idx_reg;
   logic shi_prev_reg;
   logic start_now;
   logic result_load;
   logic flag_set;
   logic flag_next;
   logic trig_rise;
   logic sample_hold_input;
   logic shi_raw;
   logic conversion_enable;
   logic multi_sample_conv;
   logic addr_ok;
   logic wr_main;
   logic wr_setup;
   logic [15:0] result_word;
   logic [15:0] rd_word;
   logic [1:0] trig_sel;
   logic [8:0] rd_idx;
   adcc_seq_t seq_mode;

   assign conversion_enable = ctl_main_reg[B_ENC];
   assign multi_sample_conv = ctl_main_reg[B_MSC];
   assign trig_sel = ctl_setup_reg[F_TRIG_MSB:F_TRIG_LSB];
   assign seq_mode = adcc_seq_t'(ctl_setup_reg[F_SEQ_MSB:F_SEQ_LSB]);

   // =========================================================
   // bus slave: zero wait states, always OKAY
   assign addr_ok = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
   assign rd_idx = i_haddr[10:2];
   assign wr_main = wr_pend_reg && (wr_idx_reg == IDX_CTL_MAIN);
   assign wr_setup = wr_pend_reg && (wr_idx_reg == IDX_CTL_SETUP);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg <= 9'h000;
      end else begin
         wr_pend_reg <= addr_ok && i_hwrite;
         if (addr_ok) begin
            wr_idx_reg <= i_haddr[10:2];
         end
      end
   end

   // result formatting happens on read so the format bit acts at once
   always_comb begin
      if (ctl_setup_reg[B_FORMAT]) begin
         result_word = {~result_reg[9], result_reg[8:0], 6'h00};
      end else begin
         result_word = {6'h00, result_reg};
      end
   end

   always_comb begin
      case (rd_idx)
         IDX_AE_LOW: rd_word = {8'h00, ae_low_reg};
         IDX_AE_HIGH: rd_word = {8'h00, ae_high_reg[7:4], 4'h0};
         IDX_CTL_MAIN: rd_word = ctl_main_reg;
         IDX_CTL_SETUP: rd_word = {ctl_setup_reg[15:1], state_reg != ST_IDLE};
         IDX_RESULT: rd_word = result_word;
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= HRESP_OKAY;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= HRESP_OKAY;
         if (addr_ok && !i_hwrite) begin
            o_hrdata <= {16'h0000, rd_word};
         end
      end
   end

   // =========================================================
   // main control word
   assign result_load = (state_reg == ST_CONVERT) && cif.done;
   assign flag_set = (result_load && !i_block_xfer_on)
      || (i_block_done && i_block_xfer_on);

   // a set in the same cycle as an accept or software clear wins
   always_comb begin
      flag_next = ctl_main_reg[B_DONE_FLAG];
      if (i_irq_ack) begin
         flag_next = 1'b0;
      end
      if (wr_main) begin
         flag_next = i_hwdata[B_DONE_FLAG];
      end
      if (flag_set) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_main_reg <= RST_CTL_MAIN;
      end else begin
         if (wr_main) begin
            if (!conversion_enable) begin
               ctl_main_reg[15:MAIN_LOCK_LSB] <= i_hwdata[15:MAIN_LOCK_LSB];
            end
            ctl_main_reg[B_DONE_IE] <= i_hwdata[B_DONE_IE];
            ctl_main_reg[B_ENC] <= i_hwdata[B_ENC];
            ctl_main_reg[B_SW_START] <= i_hwdata[B_SW_START];
         end else begin
            ctl_main_reg[B_SW_START] <= 1'b0;
         end
         ctl_main_reg[B_DONE_FLAG] <= flag_next;
      end
   end

   // =========================================================
   // setup word and analog masks
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ctl_setup_reg <= RST_CTL_SETUP;
      end else if (wr_setup && !conversion_enable) begin
         ctl_setup_reg <= {i_hwdata[15:1], 1'b0};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ae_low_reg <= RST_AE;
         ae_high_reg <= RST_AE;
      end else if (wr_pend_reg) begin
         if (wr_idx_reg == IDX_AE_LOW) begin
            ae_low_reg <= i_hwdata[7:0];
         end
         if (wr_idx_reg == IDX_AE_HIGH) begin
            ae_high_reg <= i_hwdata[7:0];
         end
      end
   end

   // =========================================================
   // trigger path
   assign shi_raw = (trig_sel == TRIG_SW) ? ctl_main_reg[B_SW_START] : i_timer_out[trig_sel - 2'h1];
   assign sample_hold_input = shi_raw ^ ctl_setup_reg[B_INVERT];
   assign trig_rise = sample_hold_input && !shi_prev_reg;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shi_prev_reg <= 1'b0;
      end else begin
         shi_prev_reg <= sample_hold_input;
      end
   end

   // =========================================================
   // sequencer
   always_comb begin
      start_now = 1'b0;
      case (state_reg)
         ST_IDLE: start_now = trig_rise && conversion_enable && ctl_main_reg[B_CONV_ON];
         ST_WAIT_TRIG: start_now = trig_rise;
         ST_CONVERT: start_now = result_load && multi_sample_conv && (seq_mode != ADCC_SEQ_SINGLE) && (
            ((seq_mode == ADCC_SEQ_SEQUENCE) && (chan_reg != CHAN_LAST)) ||
            ((seq_mode != ADCC_SEQ_SEQUENCE) && conversion_enable));
         default: start_now = 1'b0;
      endcase
   end

   assign cif.start = start_now;
   assign cif.src_sel = ctl_setup_reg[F_SRC_MSB:F_SRC_LSB];
   assign cif.div = ctl_setup_reg[F_DIV_MSB:F_DIV_LSB];

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         chan_reg <= 4'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start_now) begin
                  chan_reg <= ctl_setup_reg[F_CHAN_MSB:F_CHAN_LSB];
                  state_reg <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (result_load) begin
                  case (seq_mode)
                     ADCC_SEQ_SINGLE: state_reg <= ST_IDLE;
                     ADCC_SEQ_SEQUENCE: begin
                        if (chan_reg == CHAN_LAST) begin
                           state_reg <= ST_IDLE;
                        end else begin
                           chan_reg <= chan_reg - 4'h1;
                           state_reg <= multi_sample_conv ? ST_CONVERT : ST_WAIT_TRIG;
                        end
                     end
                     ADCC_SEQ_REPEAT_SINGLE: state_reg <= !conversion_enable ? ST_IDLE : (multi_sample_conv ? ST_CONVERT : ST_WAIT_TRIG);
                     default: begin
                        chan_reg <= (chan_reg == CHAN_LAST) ? ctl_setup_reg[F_CHAN_MSB:F_CHAN_LSB] : chan_reg - 4'h1;
                        state_reg <= !conversion_enable ? ST_IDLE : (multi_sample_conv ? ST_CONVERT : ST_WAIT_TRIG);
                     end
                  endcase
               end
            end
            ST_WAIT_TRIG: begin
               if (start_now) begin
                  state_reg <= ST_CONVERT;
               end else if (!conversion_enable && (seq_mode != ADCC_SEQ_SEQUENCE)) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         result_reg <= 10'h000;
      end else if (result_load) begin
         result_reg <= i_conv_data;
      end
   end

   adcc_conv_core #(.TICKS(TICKS)) u_core (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_src_en(i_clk_src_en),
      .bus(cif.core)
   );

   // =========================================================
   // registered outputs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
         o_ref_gen_on <= 1'b0;
         o_ref_level_sel <= 1'b0;
         o_ref_buffer_on <= 1'b0;
         o_converter_on <= 1'b0;
         o_sampling <= 1'b0;
         o_channel <= 4'h0;
         o_analog_enable <= 16'h0000;
      end else begin
         o_irq <= ctl_main_reg[B_DONE_FLAG] && ctl_main_reg[B_DONE_IE] && i_global_irq_enable;
         o_ref_gen_on <= ctl_main_reg[B_REF_ON];
         o_ref_level_sel <= ctl_main_reg[B_REF_ON] && ctl_main_reg[B_REF_LEVEL];
         o_ref_buffer_on <= ctl_main_reg[B_REF_ON] && (!ctl_main_reg[B_REF_BURST] || cif.active);
         o_converter_on <= ctl_main_reg[B_CONV_ON];
         o_sampling <= cif.active;
         o_channel <= chan_reg;
         o_analog_enable <= {ae_high_reg[7:4] & HIGH_MASK_USED, 4'h0, ae_low_reg};
      end
   end

   // =========================================================
   // assertions
   a_start_self_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      ctl_main_reg[B_SW_START] && !wr_main |=> !ctl_main_reg[B_SW_START]) else $error("start bit stuck");
   a_irq_gating: assert property (@(posedge i_clk) disable iff (i_rst)
      o_irq |-> $past(ctl_main_reg[B_DONE_FLAG] && ctl_main_reg[B_DONE_IE] && i_global_irq_enable))
      else $error("irq without enables");
   a_flag_on_result: assert property (@(posedge i_clk) disable iff (i_rst)
      result_load && !i_block_xfer_on |=> ctl_main_reg[B_DONE_FLAG]) else $error("flag not set on result");
   a_flag_on_block: assert property (@(posedge i_clk) disable iff (i_rst)
      i_block_done && i_block_xfer_on |=> ctl_main_reg[B_DONE_FLAG]) else $error("flag not set on block");
   a_flag_ack_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      i_irq_ack && !flag_set && !wr_main |=> !ctl_main_reg[B_DONE_FLAG]) else $error("flag not cleared");
   a_setup_locked: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_setup && conversion_enable |=> $stable(ctl_setup_reg)) else $error("setup written while enabled");
   a_wait_needs_edge: assert property (@(posedge i_clk) disable iff (i_rst)
      state_reg == ST_WAIT_TRIG && !trig_rise |=> state_reg != ST_CONVERT) else $error("start without edge");
   a_single_ends: assert property (@(posedge i_clk) disable iff (i_rst)
      result_load && seq_mode == ADCC_SEQ_SINGLE |=> state_reg == ST_IDLE ##1 !o_sampling)
      else $error("single mode did not stop");
   a_burst_buffer: assert property (@(posedge i_clk) disable iff (i_rst)
      o_ref_buffer_on && $past(ctl_main_reg[B_REF_BURST]) |-> $past(cif.active)) else $error("buffer on idle");
   a_level_needs_gen: assert property (@(posedge i_clk) disable iff (i_rst)
      o_ref_level_sel |-> o_ref_gen_on) else $error("level without generator");
   a_high_gap_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      o_analog_enable[11:8] == 4'h0) else $error("unused analog enables set");
   a_msc_auto_next: assert property (@(posedge i_clk) disable iff (i_rst)
      result_load && multi_sample_conv && seq_mode == ADCC_SEQ_SEQUENCE && chan_reg != CHAN_LAST
      |=> state_reg == ST_CONVERT && cif.active) else $error("no automatic restart");

   c_single_conv: cover property (@(posedge i_clk) disable iff (i_rst)
      result_load && seq_mode == ADCC_SEQ_SINGLE);
   c_auto_next: cover property (@(posedge i_clk) disable iff (i_rst) result_load && start_now);
   c_set_beats_ack: cover property (@(posedge i_clk) disable iff (i_rst) flag_set && i_irq_ack);
   c_wait_then_edge: cover property (@(posedge i_clk) disable iff (i_rst)
      state_reg == ST_WAIT_TRIG && trig_rise);
   c_burst_active: cover property (@(posedge i_clk) disable iff (i_rst)
      ctl_main_reg[B_REF_BURST] && o_ref_buffer_on);
endmodule : adcc_top

// ==== verification/adcc_tb.sv ====
// self-checking bench for the converter control block, registers over ahb-lite
// assumes adcc_pkg and adcc_top compiled first; clock sources are random enable pulses
`timescale 1ns/1ps
module testbench;
   import adcc_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic glob = 1'b1;
   logic ack = 1'b0;
   logic bx_on = 1'b0;
   logic bx_done = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [31:0] o_hrdata;
   logic [31:0] exp_setup;
   logic [1:0] htrans = 2'b00;
   logic [1:0] o_hresp;
   logic [1:0] src;
   logic [2:0] tmr = 3'h0;
   logic [2:0] ch;
   logic [3:0] src_en = 4'h0;
   logic [3:0] o_channel;
   logic [9:0] cdata = 10'h0;
   logic [9:0] c;
   logic [15:0] o_analog_enable;
   logic [15:0] w;
   logic o_hreadyout, o_irq, o_ref_gen_on, o_ref_level_sel, o_ref_buffer_on, o_converter_on, o_sampling;
   logic [8:0] idxs [5] = '{IDX_AE_LOW, IDX_AE_HIGH, IDX_CTL_MAIN, IDX_CTL_SETUP, IDX_RESULT};
   int miscompares = 0;
   int num_checks = 0;
   always #20 i_clk = ~i_clk;
   // random pulse density keeps conversion length unpredictable to the design
   always @(posedge i_clk) src_en <= 4'($urandom);
   adcc_top #(.TICKS(2)) adcc_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(o_hreadyout),
      .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_timer_out(tmr),
      .i_clk_src_en(src_en), .i_conv_data(cdata), .i_global_irq_enable(glob), .i_irq_ack(ack),
      .i_block_xfer_on(bx_on), .i_block_done(bx_done), .o_irq(o_irq), .o_ref_gen_on(o_ref_gen_on),
      .o_ref_level_sel(o_ref_level_sel), .o_ref_buffer_on(o_ref_buffer_on), .o_converter_on(o_converter_on),
      .o_sampling(o_sampling), .o_channel(o_channel), .o_analog_enable(o_analog_enable));
   // ==========================================================
   // checking and bus tasks
   task give_verdict;
      if (miscompares == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic wait_sig(ref logic s, input logic v);
      int n;
      n = 0;
      @(posedge i_clk);
      while (s !== v) begin
         n++;
         if (n > 400) begin
            chk(1'b0, 1'b1, "wait timed out");
            give_verdict();
         end
         @(posedge i_clk);
      end
   endtask : wait_sig
   task bus(input logic w_n, input logic [8:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w_n;
      haddr <= {21'h0, idx, 2'b00};
      wait_sig(o_hreadyout, 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_sig(o_hreadyout, 1'b1);
      rd = o_hrdata;
      chk(o_hresp, HRESP_OKAY, "bus response");
   endtask : bus
   task wr(input logic [8:0] idx, input logic [31:0] wd);
      bus(1'b1, idx, wd);
   endtask : wr
   task rdchk(input logic [8:0] idx, input logic [31:0] exp, input string m);
      bus(1'b0, idx, 32'h0);
      chk(rd, exp, m);
   endtask : rdchk
   // counts conversions started in a fixed window; o_sampling dips one cycle between chained ones
   task automatic count_conv(input int exp_n, input logic [3:0] exp_ch, input string m);
      int n;
      logic prev;
      n = 0;
      prev = 1'b0;
      repeat (300) begin
         @(posedge i_clk);
         if (o_sampling && !prev) begin
            n++;
         end
         prev = o_sampling;
      end
      chk(n, exp_n, m);
      chk(o_channel, exp_ch, m);
   endtask : count_conv
   function automatic logic [31:0] fmt_res(input logic [9:0] r, input logic f);
      return f ? {16'h0, ~r[9], r[8:0], 6'h00} : {22'h0, r};
   endfunction : fmt_res
   function automatic logic [31:0] setup(input logic [3:0] chn, input logic [1:0] t, input logic f,
                                         input logic inv, input logic [2:0] d, input logic [1:0] s);
      return {16'h0, chn, t, f, inv, d, s, 2'b00, 1'b0};
   endfunction : setup
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(63451));
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         rdchk(idxs[k], 32'h0, "reset value");
      end
      wr(9'h1FF, 32'hFFFF);
      rdchk(9'h1FF, 32'h0, "unmapped read");
      w = 16'($urandom);
      wr(IDX_AE_LOW, {24'h0, w[7:0]});
      wr(IDX_AE_HIGH, {24'h0, w[15:8]});
      rdchk(IDX_AE_LOW, {24'h0, w[7:0]}, "low mask");
      rdchk(IDX_AE_HIGH, {24'h0, w[15:12], 4'h0}, "high mask");
      chk(o_analog_enable, {w[15:12], 4'h0, w[7:0]}, "analog enable pins");
      wr(IDX_CTL_MAIN, 32'h0050);
      repeat (2) @(posedge i_clk);
      chk({o_ref_gen_on, o_ref_level_sel, o_converter_on}, 3'b001, "level without generator");
      wr(IDX_CTL_MAIN, 32'h0170);
      repeat (2) @(posedge i_clk);
      chk({o_ref_gen_on, o_ref_level_sel, o_converter_on, o_ref_buffer_on}, 4'hE, "burst idle");
      wr(IDX_CTL_MAIN, 32'h0011);
      repeat (5) @(posedge i_clk);
      chk({o_ref_gen_on, o_converter_on, o_sampling}, 3'b010, "start without enable");
      c = 10'($urandom);
      ch = 3'($urandom);
      src = 2'($urandom);
      cdata <= c;
      exp_setup = setup({1'b0, ch}, 2'b00, 1'b0, 1'b0, 3'($urandom), src);
      wr(IDX_CTL_SETUP, exp_setup);
      wr(IDX_CTL_MAIN, 32'h001B);
      // the start bit makes its edge one cycle after the write; busy follows one edge later
      @(posedge i_clk);
      rdchk(IDX_CTL_SETUP, exp_setup | 32'h1, "busy during conversion");
      chk(o_channel, {1'b0, ch}, "channel during conversion");
      wait_sig(o_irq, 1'b1);
      rdchk(IDX_RESULT, fmt_res(c, 1'b0), "binary result");
      rdchk(IDX_CTL_MAIN, 32'h001E, "flag set, start cleared");
      wr(IDX_CTL_SETUP, 32'hFFFE);
      rdchk(IDX_CTL_SETUP, exp_setup, "setup locked");
      ack <= 1'b1;
      @(posedge i_clk);
      ack <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk(o_irq, 1'b0, "irq after accept");
      rdchk(IDX_CTL_MAIN, 32'h001A, "flag after accept");
      glob <= 1'b0;
      wr(IDX_CTL_MAIN, 32'h001E);
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'b0, "irq masked globally");
      glob <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk(o_irq, 1'b1, "irq unmasked");
      wr(IDX_CTL_MAIN, 32'h001A);
      repeat (2) @(posedge i_clk);
      chk(o_irq, 1'b0, "software clear");
      // block transfer mode with two's complement result
      wr(IDX_CTL_MAIN, 32'h0010);
      c = 10'($urandom);
      cdata <= c;
      wr(IDX_CTL_SETUP, setup({1'b0, ch}, 2'b00, 1'b1, 1'b0, 3'h7, src));
      bx_on <= 1'b1;
      wr(IDX_CTL_MAIN, 32'h001B);
      wait_sig(o_sampling, 1'b1);
      wait_sig(o_sampling, 0);
      repeat (3) @(posedge i_clk);
      rdchk(IDX_CTL_MAIN, 32'h001A, "no flag per result");
      rdchk(IDX_RESULT, fmt_res(c, 1'b1), "left justified result");
      bx_done <= 1'b1;
      @(posedge i_clk);
      bx_done <= 1'b0;
      repeat (2) @(posedge i_clk);
      rdchk(IDX_CTL_MAIN, 32'h001E, "flag on block done");
      bx_on <= 1'b0;
      // timer triggers; the last one inverted so only the falling edge starts
      for (int t = 1; t < 4; t++) begin
         wr(IDX_CTL_MAIN, 32'h0010);
         wr(IDX_CTL_SETUP, setup({1'b0, ch}, 2'(t), 1'b0, t == 3, 3'h7, src));
         wr(IDX_CTL_MAIN, 32'h0012);
         tmr[t-1] <= 1'b1;
         repeat (5) @(posedge i_clk);
         chk(o_sampling, t != 3, "timer trigger");
         tmr <= 3'h0;
         wait_sig(o_sampling, 1'b1);
         wait_sig(o_sampling, 1'b0);
      end
      // multi-sample sequence from channel 2 down, with burst reference
      wr(IDX_CTL_MAIN, 32'h0010);
      wr(IDX_CTL_SETUP, setup(4'h2, 2'b00, 1'b0, 1'b0, 3'h0, src) | 32'h2);
      wr(IDX_CTL_MAIN, 32'h01B3);
      count_conv(3, 4'h0, "multi-sample sequence");
      // without multi-sample each step of the sequence waits for its own edge
      wr(IDX_CTL_MAIN, 32'h0010);
      wr(IDX_CTL_SETUP, setup(4'h1, 2'b00, 1'b0, 1'b0, 3'h0, src) | 32'h2);
      wr(IDX_CTL_MAIN, 32'h0013);
      count_conv(1, 4'h0, "first step of sequence");
      rdchk(IDX_CTL_SETUP, setup(4'h1, 2'b00, 1'b0, 1'b0, 3'h0, src) | 32'h3, "busy between steps");
      wr(IDX_CTL_MAIN, 32'h0013);
      count_conv(1, 4'h0, "second step of sequence");
      rdchk(IDX_CTL_SETUP, setup(4'h1, 2'b00, 1'b0, 1'b0, 3'h0, src) | 32'h2, "sequence done");
      give_verdict();
   end
endmodule : testbench
